// File: hw/period_timer_pkg.sv
// constants for the 8-bit period timer with postscaler
// assumes a single 100 MHz clock and no register bus (plain control ports)
package period_timer_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;           // core clock period

  // widths
  localparam int unsigned COUNT_W   = 8;                // count and period width
  localparam int unsigned POST_W    = 5;                // postscale select width
  localparam int unsigned PRE_SEL_W = 3;                // prescale select width
  localparam int unsigned PRE_CNT_W = 7;                // prescaler counter, ratio up to 1:128
  localparam int unsigned SRC_W     = 4;                // external source select width
  localparam int unsigned SRC_N     = 16;               // number of external sources

  // reset values
  localparam logic [7:0] COUNT_RST  = 8'h00;            // count after reset
  localparam logic [7:0] PERIOD_RST = 8'hff;            // period after reset
  localparam logic [4:0] POST_RST   = 5'h00;            // postscaler count after clear

  // mode field layout: bits 4:3 major mode, bits 2:0 option
  localparam int unsigned MODE_MAJOR_HI = 4;
  localparam int unsigned MODE_MAJOR_LO = 3;
  localparam int unsigned MODE_OPT_HI   = 2;
  localparam int unsigned MODE_OPT_LO   = 0;

  // major modes
  localparam logic [1:0] MAJOR_FREE = 2'h0;             // free-running period
  localparam logic [1:0] MAJOR_ONE  = 2'h1;             // one-shot
  localparam logic [1:0] MAJOR_MONO = 2'h2;             // monostable (3 behaves the same)

  // start, stop and reset options
  localparam logic [2:0] OPT_SW       = 3'h0;           // software run enable only
  localparam logic [2:0] OPT_GATE_HI  = 3'h1;           // counts while source high
  localparam logic [2:0] OPT_GATE_LO  = 3'h2;           // counts while source low
  localparam logic [2:0] OPT_RST_RISE = 3'h3;           // reset on rising edge
  localparam logic [2:0] OPT_RST_FALL = 3'h4;           // reset on falling edge
  localparam logic [2:0] OPT_RST_ANY  = 3'h5;           // reset on either edge
  localparam logic [2:0] OPT_RST_HI   = 3'h6;           // held in reset while high
  localparam logic [2:0] OPT_RST_LO   = 3'h7;           // held in reset while low

  // minimum source spacing the far side must keep, in timer clock periods
  localparam int unsigned EDGE_SPACING_TICKS = 6;
  localparam int unsigned LEVEL_HOLD_TICKS   = 3;

endpackage

// File: hw/tick_if.sv
// carrier between the timer core and its prescaler
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic                                  clear;   // restart the prescaler
  logic [period_timer_pkg::PRE_SEL_W-1:0] sel;     // ratio is 2**sel
  logic                                  tick;    // one-cycle prescaled tick

  modport gen (input clear, input sel, output tick);
  modport use_side (output clear, output sel, input tick);
endinterface
`default_nettype wire

// File: hw/tick_prescaler.sv
// programmable prescaler: one-cycle tick every 2**sel clocks
// assumes clear arrives from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler (
  input  wire logic clk_i,     // core clock
  input  wire logic rstn_i,    // async reset, active low
  tick_if.gen       tk         // clear, select and tick
);
  logic [period_timer_pkg::PRE_CNT_W-1:0] cnt_q;   // divider count
  logic [period_timer_pkg::PRE_CNT_W-1:0] cnt_d;   // next divider count
  logic [period_timer_pkg::PRE_CNT_W-1:0] limit;   // last count before a tick
  logic                                   wrap;    // divider at its limit

  assign limit = period_timer_pkg::PRE_CNT_W'((32'h1 << tk.sel) - 32'h1);
  assign wrap  = (cnt_q >= limit);
  // a clear suppresses the tick so a restart always begins a full period
  assign tk.tick = wrap && !tk.clear;
  assign cnt_d = (tk.clear || wrap) ? '0 : cnt_q + 1'b1;

  // divider register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// File: hw/period_timer.sv
// 8-bit period timer with prescaler, postscaler and hardware gate or reset
// assumes software strobes are one-cycle pulses on clk_i and ext sources are asynchronous
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R01: free-running, one-shot and monostable modes with options
// R02: count advances once per prescaled tick
// R03: match flags postscaler; count clears next tick
// R04: gate options freeze count while gate inactive
// R05: reset options clear count by level or edge
// R06: software reads and writes count and period
// R07: reset gives count zero, period all ones
// R08: count or control write clears pre/postscalers
// R09: external reset event clears pre/postscalers
// R10: match restarts count and advances postscaler
// R11: postscaler hit gives one-tick pulse, then clears
// R12: one-shot drops run enable at first match
// R13: one-shot postscale other than zero is useless
// R14: monostable halts at match; external event restarts
// R15: five-bit mode field, separate source select
// R16: source keeps six-tick spacing, three-tick levels
// R17: external triggers ignored during debug freeze
// R18: halted timer holds count, pulse stays low
module period_timer (
  input  wire logic                                      clk_i,                        // core clock
  input  wire logic                                      rstn_i,                       // async reset, active low
  input  wire logic                                      count_wr_i,                   // software write of count
  input  wire logic [period_timer_pkg::COUNT_W-1:0]      count_wdata_i,                // value written to count
  input  wire logic                                      period_wr_i,                  // software write of period
  input  wire logic [period_timer_pkg::COUNT_W-1:0]      period_wdata_i,               // value written to period
  input  wire logic                                      ctrl_wr_i,                    // control register write
  input  wire logic                                      ctrl_run_enable_i,            // run enable written
  input  wire logic [period_timer_pkg::PRE_SEL_W-1:0]    ctrl_prescale_i,              // prescale select written
  input  wire logic [period_timer_pkg::POST_W-1:0]       ctrl_postscale_select_i,      // postscale select written
  input  wire logic [4:0]                                mode_i,                       // mode and option
  input  wire logic [period_timer_pkg::SRC_W-1:0]        ext_reset_source_select_i,    // source chooser
  input  wire logic [period_timer_pkg::SRC_N-1:0]        ext_sources_i,                // candidate sources
  input  wire logic                                      debug_freeze_i,               // debugger freeze
  output logic [period_timer_pkg::COUNT_W-1:0]           period_count_o,               // count readback
  output logic [period_timer_pkg::COUNT_W-1:0]           period_match_value_o,         // period readback
  output logic                                           run_enable_o,                 // run enable readback
  output logic                                           halted_o,                     // monostable halt state
  output logic                                           postscaled_period_pulse_o     // postscaled pulse
);

  // edge of interest for the selected reset option
  function automatic logic edge_hit(input logic [2:0] opt, input logic rise, input logic fall);
    edge_hit = ((opt == period_timer_pkg::OPT_RST_RISE) && rise) ||
               ((opt == period_timer_pkg::OPT_RST_FALL) && fall) ||
               ((opt == period_timer_pkg::OPT_RST_ANY)  && (rise || fall));
  endfunction

  // control state
  logic                                   run_q, run_d;          // run enable
  logic                                   halt_q, halt_d;        // monostable stop
  logic [period_timer_pkg::PRE_SEL_W-1:0] pre_sel_q;             // prescale select
  logic [period_timer_pkg::POST_W-1:0]    post_sel_q;            // postscale select
  logic [period_timer_pkg::COUNT_W-1:0]   count_q, count_d;      // timer count
  logic [period_timer_pkg::COUNT_W-1:0]   period_q;              // period value
  logic [period_timer_pkg::POST_W-1:0]    post_q, post_d;        // postscaler count
  logic                                   pulse_q, pulse_d;      // postscaled pulse

  // three-stage synchroniser; only stage two and three are compared
  logic                                   src_s1_q;              // first stage, feeds s2 only
  logic                                   src_s2_q;              // second stage
  logic                                   src_s3_q;              // third stage
  logic                                   src_lvl_q;             // accepted level
  logic                                   src_new;               // accepted level next

  // mode decode
  logic [1:0]                             major;                 // major mode
  logic [2:0]                             opt;                   // option
  logic                                   ext_live;              // triggers honoured
  logic                                   rise, fall;            // accepted edges
  logic                                   gate_ok;               // gate allows counting
  logic                                   lvl_rst;               // level reset active
  logic                                   edge_rst;              // edge reset event
  logic                                   ext_rst;               // any external reset
  logic                                   running;               // timer may count
  logic                                   tick;                  // prescaled tick
  logic                                   step;                  // tick that counts
  logic                                   match;                 // count equals period
  logic                                   post_hit;              // postscaler at select

  tick_if tk ();                                                 // prescaler carrier

  tick_prescaler u_pre (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tk     (tk)
  );

  // a change counts once stages two and three agree
  assign src_new  = (src_s2_q == src_s3_q) ? src_s3_q : src_lvl_q;
  assign major    = mode_i[period_timer_pkg::MODE_MAJOR_HI:period_timer_pkg::MODE_MAJOR_LO];  // [R15]
  assign opt      = mode_i[period_timer_pkg::MODE_OPT_HI:period_timer_pkg::MODE_OPT_LO];      // [R15]
  assign ext_live = !debug_freeze_i;                                                         // [R17]
  assign rise     = ext_live && src_new && !src_lvl_q;
  assign fall     = ext_live && !src_new && src_lvl_q;

  // gate freezes counting while inactive; debug freeze forces the gate off
  assign gate_ok  = (opt == period_timer_pkg::OPT_GATE_HI) ? (src_lvl_q && ext_live) :       // [R04]
                    (opt == period_timer_pkg::OPT_GATE_LO) ? (!src_lvl_q && ext_live) : 1'b1; // [R04]
  assign lvl_rst  = ext_live && (((opt == period_timer_pkg::OPT_RST_HI) && src_lvl_q) ||      // [R05]
                                 ((opt == period_timer_pkg::OPT_RST_LO) && !src_lvl_q));
  assign edge_rst = edge_hit(opt, rise, fall);                                               // [R05]
  assign ext_rst  = lvl_rst || edge_rst;

  // prescaler restarts on count write, control write or external reset
  assign tk.clear = count_wr_i || ctrl_wr_i || ext_rst;                                      // [R08] [R09]
  assign tk.sel   = pre_sel_q;
  assign tick     = tk.tick;

  assign running  = run_q && !halt_q;                                                        // [R18]
  assign step     = tick && running && gate_ok && !ext_rst;                                  // [R02] [R04]
  assign match    = (count_q == period_q);                                                   // [R03] [R10]
  assign post_hit = (post_q == post_sel_q);                                                  // [R11]

  // next count: software write wins, then external reset, then counting
  always_comb begin
    count_d = count_q;
    if (count_wr_i) begin
      count_d = count_wdata_i;                                                               // [R06]
    end else if (ext_rst) begin
      count_d = period_timer_pkg::COUNT_RST;                                                 // [R05]
    end else if (step) begin
      count_d = match ? period_timer_pkg::COUNT_RST : count_q + 1'b1;                        // [R03] [R10]
    end
  end

  // postscaler and its pulse; a clear wipes both
  always_comb begin
    post_d  = post_q;
    pulse_d = pulse_q;
    if (tk.clear || !running) begin
      post_d  = period_timer_pkg::POST_RST;                                                  // [R08] [R09]
      pulse_d = 1'b0;                                                                        // [R18]
    end else if (step) begin
      pulse_d = 1'b0;                     // pulse drops at the next counting tick unless that tick hits again
      if (match) begin
        if (post_hit) begin
          post_d  = period_timer_pkg::POST_RST;                                              // [R11]
          pulse_d = 1'b1;                                                                    // [R11]
        end else begin
          post_d  = post_q + 1'b1;                                                           // [R10]
        end
      end
    end
  end

  // run enable and monostable halt
  always_comb begin
    run_d  = run_q;
    halt_d = halt_q;
    if (step && match) begin
      case (major)                  // [R01]
        period_timer_pkg::MAJOR_FREE: begin
          halt_d = halt_q;
        end
        period_timer_pkg::MAJOR_ONE: begin
          run_d = 1'b0;     // stays off until software cycles it  [R12] [R13]
        end
        default: begin
          halt_d = 1'b1;    // monostable keeps run enable set  [R14]
        end
      endcase
    end
    if (edge_rst && (major != period_timer_pkg::MAJOR_FREE) && (major != period_timer_pkg::MAJOR_ONE)) begin
      halt_d = 1'b0;        // external event restarts a stopped monostable  [R14]
    end
    if (ctrl_wr_i) begin
      run_d  = ctrl_run_enable_i;   // software write takes priority
      halt_d = 1'b0;
    end
  end

  // synchroniser stages
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_s1_q  <= 1'b0;
      src_s2_q  <= 1'b0;
      src_s3_q  <= 1'b0;
      src_lvl_q <= 1'b0;
    end else begin
      src_s1_q  <= ext_sources_i[ext_reset_source_select_i];                                 // [R15]
      src_s2_q  <= src_s1_q;
      src_s3_q  <= src_s2_q;
      src_lvl_q <= src_new;
    end
  end

  // control fields
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q      <= 1'b0;
      halt_q     <= 1'b0;
      pre_sel_q  <= '0;
      post_sel_q <= '0;
    end else begin
      run_q  <= run_d;
      halt_q <= halt_d;
      if (ctrl_wr_i) begin
        pre_sel_q  <= ctrl_prescale_i;
        post_sel_q <= ctrl_postscale_select_i;
      end
    end
  end

  // count, period and postscaler
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q  <= period_timer_pkg::COUNT_RST;                                               // [R07]
      period_q <= period_timer_pkg::PERIOD_RST;                                              // [R07]
      post_q   <= period_timer_pkg::POST_RST;                                                // [R08]
      pulse_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      post_q  <= post_d;
      pulse_q <= pulse_d;
      if (period_wr_i) begin
        period_q <= period_wdata_i;                                                          // [R06]
      end
    end
  end

  // readback straight from flip-flops
  assign period_count_o            = count_q;
  assign period_match_value_o      = period_q;
  assign run_enable_o              = run_q;
  assign halted_o                  = halt_q;
  assign postscaled_period_pulse_o = pulse_q;

endmodule
`default_nettype wire

// File: test/period_timer_props.sv
// checker for the period timer, port relations only
// assumes it is bound onto period_timer and shares its clock and reset
`timescale 1ns/1ps
`default_nettype none
module period_timer_props (
  input wire logic       clk_i,                     // core clock
  input wire logic       rstn_i,                    // async reset, active low
  input wire logic       count_wr_i,                // count write strobe
  input wire logic [7:0] count_wdata_i,             // count write data
  input wire logic       period_wr_i,               // period write strobe
  input wire logic [7:0] period_wdata_i,            // period write data
  input wire logic       ctrl_wr_i,                 // control write strobe
  input wire logic [4:0] mode_i,                    // mode and option
  input wire logic       debug_freeze_i,            // debugger freeze
  input wire logic [7:0] period_count_o,            // count readback
  input wire logic [7:0] period_match_value_o,      // period readback
  input wire logic       run_enable_o,              // run enable readback
  input wire logic       halted_o,                  // monostable halt
  input wire logic       postscaled_period_pulse_o  // postscaled pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // count sat on the period last cycle and has now wrapped
  sequence s_wrapped;
    $past(period_count_o) == $past(period_match_value_o) && period_count_o == 8'h00;
  endsequence
  // freeze held long enough to cover the source synchroniser
  sequence s_frozen_halt;
    debug_freeze_i [*5] ##0 (halted_o && !ctrl_wr_i);
  endsequence
  a_reset_state: assert property (
    !$past(rstn_i) |-> period_count_o == 8'h00 && period_match_value_o == 8'hff) else $error("bad reset state");
  a_count_load: assert property (
    count_wr_i |=> period_count_o == $past(count_wdata_i)) else $error("count write lost");
  a_period_load: assert property (
    period_wr_i |=> period_match_value_o == $past(period_wdata_i)) else $error("period write lost");
  a_count_step: assert property (
    !$past(count_wr_i) && period_count_o != $past(period_count_o)
      |-> period_count_o == 8'($past(period_count_o) + 8'h01) || period_count_o == 8'h00)
    else $error("count moved by other than one");
  a_stopped_hold: assert property (
    (!run_enable_o || halted_o) && mode_i[2:0] < 3'h3 && !count_wr_i |=> $stable(period_count_o))
    else $error("stopped count moved");
  a_pulse_idle: assert property (
    !run_enable_o && !$past(run_enable_o) |-> !postscaled_period_pulse_o) else $error("pulse while stopped");
  a_pulse_cause: assert property (
    $rose(postscaled_period_pulse_o) && !halted_o |-> s_wrapped) else $error("pulse without match");
  a_oneshot_clear: assert property (
    $fell(run_enable_o) && !$past(ctrl_wr_i) |-> $past(mode_i[4:3]) == 2'h1 && period_count_o == 8'h00)
    else $error("run enable dropped wrongly");
  a_mono_halt: assert property (
    $rose(halted_o) |-> run_enable_o && mode_i[4]) else $error("halt outside monostable");
  a_freeze_ignore: assert property (
    s_frozen_halt |=> halted_o) else $error("trigger taken during freeze");
endmodule
bind period_timer period_timer_props u_props (.clk_i, .rstn_i, .count_wr_i, .count_wdata_i, .period_wr_i,
  .period_wdata_i, .ctrl_wr_i, .mode_i, .debug_freeze_i, .period_count_o, .period_match_value_o,
  .run_enable_o, .halted_o, .postscaled_period_pulse_o);
`default_nettype wire

// File: test/ext_source_model.sv
// far-side trigger source feeding the timer's gate or reset input
// assumes the same clock as the timer at prescale 1:1
`timescale 1ns/1ps
`default_nettype none
module ext_source_model (
  input  wire logic clk_i,   // core clock
  input  wire logic want_i,  // level the bench asks for
  output logic      src_o    // trigger line
);
  logic [3:0] age_q = 4'h0;  // cycles since the last change
  logic       lvl_q = 1'b0;  // level now on the line, idle low
  assign src_o = lvl_q;
  // a request waits until the last level stood long enough; also covers the hold minimum
  always @(posedge clk_i) begin
    if (want_i !== lvl_q && age_q >= 4'(period_timer_pkg::EDGE_SPACING_TICKS)) begin
      lvl_q <= want_i;
      age_q <= 4'h0;
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: test/period_timer_tb.sv
// self-checking bench for the period timer
// assumes the checker is bound in and the source model drives source 0
`timescale 1ns/1ps
`default_nettype none
module period_timer_tb;
  typedef struct packed {logic [2:0] sel; logic [7:0] per; logic [4:0] post; logic [15:0] gap;} row_t;
  // prescale, period, postscale and expected cycles between pulses
  localparam row_t ROWS [5] = '{'{3'h0, 8'h02, 5'h00, 16'h3}, '{3'h2, 8'h02, 5'h00, 16'hc},
    '{3'h0, 8'h04, 5'h02, 16'hf}, '{3'h0, 8'h01, 5'h1f, 16'h40}, '{3'h0, 8'hff, 5'h00, 16'h100}};
  logic clk_i, rstn_i, cwr, pwr, kwr, krun, freeze, want, src;  // stimulus
  logic [7:0] cwd, pwd, count, per;                              // data
  logic [2:0] kpre;                                              // prescale select
  logic [4:0] kpost, mode;                                       // postscale, mode
  logic run, halt, pulse;                                        // status
  int error_cnt, comparisons, n;                                 // tallies
  period_timer dut (.clk_i, .rstn_i, .count_wr_i(cwr), .count_wdata_i(cwd), .period_wr_i(pwr),
    .period_wdata_i(pwd), .ctrl_wr_i(kwr), .ctrl_run_enable_i(krun), .ctrl_prescale_i(kpre),
    .ctrl_postscale_select_i(kpost), .mode_i(mode), .ext_reset_source_select_i(4'h0),
    .ext_sources_i({15'h0, src}), .debug_freeze_i(freeze), .period_count_o(count),
    .period_match_value_o(per), .run_enable_o(run), .halted_o(halt), .postscaled_period_pulse_o(pulse));
  ext_source_model src_m (.clk_i, .want_i(want), .src_o(src));
  // clock at 100 MHz
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, entered at a falling edge
  task ctrl(input logic r, input logic [2:0] s, input logic [4:0] p);
    krun = r; kpre = s; kpost = p; kwr = 1'b1;
    @(negedge clk_i) kwr = 1'b0;
  endtask
  task wr(input logic k, input logic [7:0] v);
    if (k) begin pwd = v; pwr = 1'b1; end else begin cwd = v; cwr = 1'b1; end
    @(negedge clk_i) begin if (k) pwr = 1'b0; else cwr = 1'b0; end
  endtask
  // cycles until the pulse next rises, bounded
  task automatic rise(output int c);
    logic p;
    c = 0; p = 1'b1;
    while (!(p === 1'b0 && pulse === 1'b1) && c < 2000) begin
      p = pulse; @(negedge clk_i); c++;
    end
  endtask
  task final_report;
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog well beyond the expected thousand or so cycles
  initial begin
    #200us;
    error_cnt++;
    final_report;
  end
  // main sequence
  initial begin
    {cwr, pwr, kwr, krun, freeze, want, cwd, pwd, kpre, kpost, mode} = '0;
    error_cnt = 0; comparisons = 0; rstn_i = 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i) rstn_i = 1'b1;
    chk(count, 16'h0); chk(per, 16'hff); chk(run, 16'h0);
    // free-running rows: spacing of postscaled pulses
    foreach (ROWS[i]) begin
      ctrl(1'b0, 3'h0, 5'h0);
      wr(1'b1, ROWS[i].per);
      chk(per, 16'(ROWS[i].per));
      ctrl(1'b1, ROWS[i].sel, ROWS[i].post);
      rise(n);
      rise(n);
      chk(16'(n), ROWS[i].gap);
      @(negedge clk_i) chk(pulse, {15'h0, ROWS[i].sel != 3'h0});
    end
    // control write keeps the count
    ctrl(1'b0, 3'h0, 5'h0);
    wr(1'b0, 8'h42);
    ctrl(1'b0, 3'h3, 5'h1);
    chk(count, 16'h42);
    // one-shot stops at the first match
    wr(1'b1, 8'h05); mode = 5'h08; wr(1'b0, 8'h00); ctrl(1'b1, 3'h0, 5'h0);
    for (n = 0; n < 50 && run !== 1'b0; n++) @(negedge clk_i);
    chk(count, 16'h0);
    repeat (10) @(negedge clk_i);
    chk({pulse, run, count}, 16'h0);
    ctrl(1'b1, 3'h0, 5'h0);
    repeat (3) @(negedge clk_i);
    chk(count, 16'h3);
    // gate high: frozen while the source is low
    wr(1'b1, 8'hff); mode = 5'h01; wr(1'b0, 8'h00); ctrl(1'b1, 3'h0, 5'h0);
    repeat (20) @(negedge clk_i);
    chk(count, 16'h0);
    want = 1'b1;
    repeat (20) @(negedge clk_i);
    chk(count == 8'h00, 16'h0);
    // level reset: held at zero while the source is high
    mode = 5'h06;
    repeat (20) @(negedge clk_i);
    chk(count, 16'h0);
    want = 1'b0;
    repeat (20) @(negedge clk_i);
    chk(count == 8'h00, 16'h0);
    // gate low: frozen while the source is high
    mode = 5'h02;
    want = 1'b1;
    repeat (20) @(negedge clk_i);
    n = count;
    repeat (10) @(negedge clk_i);
    chk(count, 16'(n));
    want = 1'b0;
    // monostable, rising-edge restart, freeze first
    wr(1'b1, 8'h04); mode = 5'h13; wr(1'b0, 8'h00); ctrl(1'b1, 3'h0, 5'h0);
    for (n = 0; n < 50 && halt !== 1'b1; n++) @(negedge clk_i);
    chk({halt, run}, 16'h3);
    freeze = 1'b1; want = 1'b1;
    repeat (15) @(negedge clk_i);
    chk(halt, 16'h1);
    want = 1'b0;
    repeat (10) @(negedge clk_i);
    freeze = 1'b0; want = 1'b1;
    for (n = 0; n < 20 && halt !== 1'b0; n++) @(negedge clk_i);
    chk(halt, 16'h0);
    // reset in mid-run: every output back to its reset value
    wr(1'b1, 8'h30);
    rstn_i = 1'b0;
    @(negedge clk_i) chk({pulse, halt, run, count}, 16'h0);
    chk(per, 16'hff);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_i) chk({run, count}, 16'h0);
    final_report;
  end
endmodule
`default_nettype wire
